// [verilog/channel_irq_pkg.sv]
// Shared constants and types for the channel interrupt control block
package channel_irq_pkg;

    // ****************************************************************
    // Bus carrier and widths
    // ****************************************************************
    localparam int unsigned DATA_W = 32;  // Avalon data width
    localparam int unsigned WORD_W = 16;  // Control word width
    localparam int unsigned NUM_TYPES = 6;  // Interrupt types
    localparam int unsigned EVT_W = 3;  // Sticky event bits

    // Request from the Avalon master, grouped
    typedef struct packed {
        logic [3:0] address;  // Byte address
        logic read;  // Read request
        logic write;  // Write request
        logic [31:0] writedata;  // Write data
        logic [3:0] byteenable;  // Byte lanes
    } avmm_req_t;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [3:0] OFF_CONTROL = 4'h0;  // interrupt_control
    localparam logic [3:0] OFF_EVENT = 4'h4;  // Sticky events, W1C
    localparam logic [3:0] OFF_MASK = 4'h8;  // Event mask
    localparam logic [3:0] OFF_VIEW = 4'hc;  // Live state, read only

    // ****************************************************************
    // Control word field positions
    // ****************************************************************
    localparam int unsigned MASTER_EN_BIT = 15;  // master_interrupt_enable
    localparam int unsigned COB_BIT = 14;  // chain_output_block
    localparam int unsigned NO_VEC_BIT = 13;  // no_vector_mode
    localparam int unsigned VSS_HI = 12;  // vector_status_select top
    localparam int unsigned VSS_LO = 9;  // vector_status_select bottom
    localparam int unsigned OP_HI = 7;  // enable_update_op top
    localparam int unsigned OP_LO = 6;  // enable_update_op bottom
    localparam logic [1:0] OP_CLEAR = 2'h2;  // Clear masked enables
    localparam logic [1:0] OP_SET = 2'h3;  // Set masked enables
    localparam logic [6:0] CTRL_RESET = 7'h00;  // Bits 15..9 at reset
    localparam logic [5:0] IE_RESET = 6'h00;  // Enables at reset

    // ****************************************************************
    // Interrupt type codes, index = enable bit + 1
    // ****************************************************************
    localparam logic [2:0] TYPE_NONE = 3'h0;
    localparam logic [2:0] TYPE_MISC = 3'h1;
    localparam logic [2:0] TYPE_IOP = 3'h2;
    localparam logic [2:0] TYPE_TD = 3'h3;
    localparam logic [2:0] TYPE_TS = 3'h4;
    localparam logic [2:0] TYPE_RD = 3'h5;
    localparam logic [2:0] TYPE_RS = 3'h6;

    // ****************************************************************
    // Vector status select codes
    // ****************************************************************
    localparam logic [3:0] VSS_EXCEPT_MISC = 4'ha;
    localparam logic [3:0] VSS_FROM_TD = 4'hb;
    localparam logic [3:0] VSS_FROM_TS = 4'hc;
    localparam logic [3:0] VSS_FROM_RD = 4'hd;
    localparam logic [3:0] VSS_ONLY_RS = 4'he;
    localparam logic [3:0] VSS_NEVER_HI = 4'hf;

    // ****************************************************************
    // Sticky event bits and bus states
    // ****************************************************************
    localparam int unsigned EVT_VECTORED = 0;  // Ack served with vector
    localparam int unsigned EVT_SILENT = 1;  // Ack served, no vector
    localparam int unsigned EVT_REQUEST = 2;  // Request went active
    localparam logic [2:0] EVT_RESET = 3'h0;

    // Gray path idle -> answer -> idle
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;

endpackage

// [verilog/vector_status_decode.sv]
// Decides whether an acknowledged type merges status into its vector
`timescale 1ns/1ps
`default_nettype none
module vector_status_decode (
    input wire logic [3:0] select,
    input wire logic [2:0] type_code,
    output logic merge_status
);
    import channel_irq_pkg::*;

    // ****************************************************************
    // Select decode
    // ****************************************************************
    // Pure decode; the caller registers the vector
    always_comb begin
        merge_status = 1'b0;
        if (!select[3]) begin
            merge_status = 1'b0;  // Never merge
        end else if (select[3:1] == 3'b100) begin
            merge_status = (type_code != TYPE_NONE);  // Always merge
        end else begin
            case (select)
                VSS_EXCEPT_MISC: begin
                    merge_status = (type_code > TYPE_MISC);
                end
                VSS_FROM_TD: begin
                    merge_status = (type_code >= TYPE_TD);
                end
                VSS_FROM_TS: begin
                    merge_status = (type_code >= TYPE_TS);
                end
                VSS_FROM_RD: begin
                    merge_status = (type_code >= TYPE_RD);
                end
                VSS_ONLY_RS: begin
                    merge_status = (type_code == TYPE_RS);
                end
                VSS_NEVER_HI: begin
                    merge_status = 1'b0;
                end
                default: begin
                    merge_status = 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [verilog/channel_interrupt_control.sv]
// Interrupt control word, chain and acknowledge logic for one channel
//
// Summary of operation
// - Requests only while master enable bit set
// - Chain block bit forces chain output inactive
// - No-vector mode suppresses vector on acknowledge
// - Select 0xxx or 1111 never merges status
// - Select 100x always merges type status
// - Select 1010 merges for all but misc
// - 1011 from transmit data, 1100 from status
// - 1101 receive types only, 1110 receive status
// - Op 10 clears masked enables, 0x nothing
// - Op 11 sets enables with mask one
// - Low six bits read back current enables
// - Mask bits zero leave enables unchanged
`timescale 1ns/1ps
`default_nettype none
module channel_interrupt_control #(
    parameter int unsigned NUM_EVT = 3  // Sticky event count
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire channel_irq_pkg::avmm_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [5:0] pending_events,
    input wire logic chain_enable_input,
    input wire logic interrupt_acknowledge_strobe,
    input wire logic [7:0] base_vector,
    output logic channel_irq_request,
    output logic chain_enable_output,
    output logic [7:0] vector_data,
    output logic vector_oe_n,
    output logic irq
);
    import channel_irq_pkg::*;

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    // Event layout is fixed by the package constants
    if (NUM_EVT != EVT_W) begin : bad_evt
        $error("NUM_EVT must equal the package event width");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Bus, control, event and vector state, each with its next value
    bus_state_t bus_reg, bus_next;  // Bus answer state
    logic [31:0] rdata_reg, rdata_next;  // Registered read data
    logic [6:0] ctrl_reg, ctrl_next;  // Bits 15..9 storage
    logic [5:0] ie_reg, ie_next;  // Per-type enables
    logic [NUM_EVT-1:0] evt_reg, evt_next;  // Sticky events
    logic [NUM_EVT-1:0] mask_reg, mask_next;  // Event mask
    logic [7:0] vec_reg, vec_next;  // Vector on the bus
    logic oe_n_reg, oe_n_next;  // Vector drive, low drives
    logic req_d_reg, req_d_next;  // Request, last cycle
    // Combinational helpers
    logic take;  // Bus request accepted now
    logic wr_lo, wr_hi;  // Control byte writes
    logic [15:0] ctrl_word;  // Readable control word
    logic [5:0] active;  // Pending and enabled
    logic [2:0] top_type;  // Highest active type
    logic local_req;  // Internal request
    logic merge;  // Merge status in vector
    logic serve;  // Acknowledge is ours
    logic [NUM_EVT-1:0] evt_set;  // Hardware event pulses

    // ****************************************************************
    // Avalon slave handshake
    // ****************************************************************
    // One wait cycle: the request is taken in IDLE, answered in ANSWER
    // Writes act at the taking edge; the master holds until the answer,
    // so software never sees the early commit
    assign take = clk_en && (bus_reg == BUS_IDLE) && (avs_req.read || avs_req.write);
    assign avs_waitrequest = (avs_req.read || avs_req.write) && (bus_reg != BUS_ANSWER);
    assign avs_readdata = rdata_reg;

    // Next bus state
    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            BUS_IDLE: begin
                if (take) begin
                    bus_next = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_next = BUS_IDLE;  // Master releases on this edge
            end
            default: begin
                bus_next = BUS_IDLE;
            end
        endcase
    end

    // Bus state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_reg <= BUS_IDLE;
        end else if (clk_en) begin
            bus_reg <= bus_next;
        end
    end

    // ****************************************************************
    // Control word
    // ****************************************************************
    // Lane 1 carries the stored bits, lane 0 the op and mask; a write
    // with one lane only leaves the other half alone
    // Op field and bit 8 are never stored, so they read zero
    assign ctrl_word = {ctrl_reg, 1'b0, 2'b00, ie_reg};
    assign wr_lo = take && avs_req.write && (avs_req.address == OFF_CONTROL)
        && avs_req.byteenable[0];
    assign wr_hi = take && avs_req.write && (avs_req.address == OFF_CONTROL)
        && avs_req.byteenable[1];

    // Stored bits 15..9 are plain storage
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_hi) begin
            ctrl_next = avs_req.writedata[MASTER_EN_BIT:VSS_LO];
        end
    end

    // Per-bit enable update, each bit on its own mask bit
    for (genvar i = 0; i < NUM_TYPES; i++) begin : g_ie
        always_comb begin
            ie_next[i] = ie_reg[i];  // Mask zero keeps it
            if (wr_lo && avs_req.writedata[i]) begin
                if (avs_req.writedata[OP_HI:OP_LO] == OP_CLEAR) begin
                    ie_next[i] = 1'b0;
                end else if (avs_req.writedata[OP_HI:OP_LO] == OP_SET) begin
                    ie_next[i] = 1'b1;
                end
                // Op 0x leaves the enable alone
            end
        end
    end

    // Control registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
            ie_reg <= IE_RESET;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
            ie_reg <= ie_next;
        end
    end

    // ****************************************************************
    // Request, priority and chain
    // ****************************************************************
    // A type asks only while its own enable is set
    assign active = pending_events & ie_reg;
    assign local_req = ctrl_reg[MASTER_EN_BIT - VSS_LO] && (|active);
    assign channel_irq_request = local_req;

    // Receive status is highest, miscellaneous lowest
    // Later passes overwrite earlier ones, so the highest index wins
    always_comb begin
        top_type = TYPE_NONE;
        for (int k = 0; k < NUM_TYPES; k++) begin
            if (active[k]) begin
                top_type = 3'(k + 1);
            end
        end
    end

    // Lower devices see the enable only when we neither block nor ask
    // Blocking the chain starves every lower device; software must
    // clear the block bit once its own service is done
    assign chain_enable_output = chain_enable_input && !ctrl_reg[COB_BIT - VSS_LO]
        && !local_req;

    // Status merge decision for the type being acknowledged
    vector_status_decode i_vector_status_decode (
        .select(ctrl_reg[VSS_HI - VSS_LO:0]),
        .type_code(top_type),
        .merge_status(merge)
    );

    // ****************************************************************
    // Acknowledge cycle
    // ****************************************************************
    // A served acknowledge reloads the vector every cycle the strobe
    // stands, so a moving base vector is followed, not latched
    // Ours when the chain hands us the enable and we are asking
    assign serve = interrupt_acknowledge_strobe && chain_enable_input && local_req;

    // Vector capture and drive control
    always_comb begin
        vec_next = vec_reg;
        oe_n_next = 1'b1;
        if (serve) begin
            if (merge) begin
                vec_next = {base_vector[7:4], top_type, base_vector[0]};
            end else begin
                vec_next = base_vector;
            end
            oe_n_next = ctrl_reg[NO_VEC_BIT - VSS_LO];  // Held off in no-vector mode
        end
    end

    // Vector registers; drive released whenever the strobe drops
    // Both follow the clock enable, like every other state here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vec_reg <= 8'h00;
            oe_n_reg <= 1'b1;
        end else if (clk_en) begin
            vec_reg <= vec_next;
            oe_n_reg <= oe_n_next;
        end
    end
    assign vector_data = vec_reg;
    assign vector_oe_n = oe_n_reg;

    // ****************************************************************
    // Sticky events and interrupt output
    // ****************************************************************
    // Event pulses from the acknowledge and request logic
    // The request event fires on the rising edge of the internal
    // request only, so a request that stays up is counted once
    always_comb begin
        evt_set = '0;
        evt_set[EVT_VECTORED] = serve && !ctrl_reg[NO_VEC_BIT - VSS_LO];
        evt_set[EVT_SILENT] = serve && ctrl_reg[NO_VEC_BIT - VSS_LO];
        evt_set[EVT_REQUEST] = local_req && !req_d_reg;
    end

    // Event and mask writes use byte lane 0 only
    // Write one to clear; a set in the same cycle wins
    always_comb begin
        evt_next = evt_reg;
        mask_next = mask_reg;
        req_d_next = local_req;
        if (take && avs_req.write && avs_req.byteenable[0]) begin
            if (avs_req.address == OFF_EVENT) begin
                evt_next = evt_reg & ~avs_req.writedata[NUM_EVT-1:0];
            end else if (avs_req.address == OFF_MASK) begin
                mask_next = avs_req.writedata[NUM_EVT-1:0];
            end
        end
        evt_next = evt_next | evt_set;
    end

    // Event registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_reg <= EVT_RESET;
            mask_reg <= EVT_RESET;
            req_d_reg <= 1'b0;
        end else if (clk_en) begin
            evt_reg <= evt_next;
            mask_reg <= mask_next;
            req_d_reg <= req_d_next;
        end
    end
    assign irq = |(evt_reg & mask_reg);

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Read data is loaded at the taking edge and then stands until
    // the next read, so the bus output never glitches
    // Unmapped offsets read zero and writes to them are dropped
    always_comb begin
        rdata_next = rdata_reg;
        if (take && avs_req.read) begin
            case (avs_req.address)
                OFF_CONTROL: begin
                    rdata_next = {16'h0000, ctrl_word};
                end
                OFF_EVENT: begin
                    rdata_next = {{(DATA_W - NUM_EVT){1'b0}}, evt_reg};
                end
                OFF_MASK: begin
                    rdata_next = {{(DATA_W - NUM_EVT){1'b0}}, mask_reg};
                end
                OFF_VIEW: begin
                    rdata_next = {16'h0000, 4'h0, local_req, top_type, 2'b00, active};
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// [bench/channel_irq_assertions.sv]
// Port-level checks for the channel interrupt control block
`timescale 1ns/1ps
`default_nettype none
module channel_irq_checks (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire channel_irq_pkg::avmm_req_t avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [5:0] pending_events,
    input wire logic chain_enable_input,
    input wire logic interrupt_acknowledge_strobe,
    input wire logic [7:0] base_vector,
    input wire logic channel_irq_request,
    input wire logic chain_enable_output,
    input wire logic [7:0] vector_data,
    input wire logic vector_oe_n,
    input wire logic irq
);
    // ****************************************************************
    // One clock domain, reset disables all
    // ****************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_req_cause: assert property (
        channel_irq_request |-> pending_events != 6'h00) else $error("request with no cause");
    chk_chain_block: assert property (
        chain_enable_output |-> chain_enable_input && !channel_irq_request)
        else $error("chain output active while blocked");
    chk_vector_cause: assert property (
        !vector_oe_n |-> $past(interrupt_acknowledge_strobe && chain_enable_input))
        else $error("vector driven without acknowledge");
    chk_oe_release: assert property (
        !interrupt_acknowledge_strobe && clk_en |=> vector_oe_n) else $error("vector held too long");
    chk_vector_base: assert property (
        !vector_oe_n |-> vector_data[7:4] == $past(base_vector[7:4])
            && vector_data[0] == $past(base_vector[0])) else $error("vector fixed bits wrong");
    chk_vector_type: assert property (
        !vector_oe_n && vector_data[3:1] != $past(base_vector[3:1])
            |-> vector_data[3:1] inside {[3'h1:3'h6]}) else $error("merged type out of range");
    chk_bus_answer: assert property (
        (avs_req.read || avs_req.write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_bus_frozen: assert property (
        !clk_en && avs_req.read && avs_waitrequest |=> avs_waitrequest)
        else $error("bus answered while frozen");
    chk_read_hold: assert property (
        !(avs_req.read && avs_waitrequest && clk_en) |=> $stable(avs_readdata))
        else $error("read data moved without read");
endmodule
bind channel_interrupt_control channel_irq_checks i_channel_irq_checks (.*);
`default_nettype wire

// [bench/ack_partner.sv]
// Host-side model: acknowledge cycles and the upstream chain enable
`timescale 1ns/1ps
`default_nettype none
module ack_partner (
    input wire logic mclk,
    input wire logic [7:0] vector_data,
    input wire logic vector_oe_n,
    output logic interrupt_acknowledge_strobe,
    output logic chain_enable_input
);
    // Idle: no acknowledge, upstream grants
    initial begin
        interrupt_acknowledge_strobe = 1'b0;
        chain_enable_input = 1'b1;
    end
    // Hold the strobe for hold edges; the vector is taken at an edge where it is driven
    task automatic ack(input int hold, input logic grant, output logic [7:0] v, output logic ok);
        ok = 1'b0;
        v = 8'h00;
        chain_enable_input <= grant;
        interrupt_acknowledge_strobe <= 1'b1;
        repeat (hold) begin
            @(posedge mclk);
            if (vector_oe_n === 1'b0) begin
                ok = 1'b1;
                v = vector_data;
            end
        end
        interrupt_acknowledge_strobe <= 1'b0;
        chain_enable_input <= 1'b1;
        // Let the release land before the next cycle
        repeat (2) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// [bench/channel_interrupt_control_test.sv]
// Self-checking bench for the channel interrupt control block
`timescale 1ns/1ps
`default_nettype none
module channel_interrupt_control_test;
    import channel_irq_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    avmm_req_t req = '0;
    logic [31:0] rdata;
    logic waitreq;
    logic [5:0] pending = 6'h00;
    logic [7:0] base = 8'h91;  // Bits 3..1 clear so any merge shows
    logic strobe, chain_in, irq_req, chain_out, oe_n, irq;
    logic [7:0] vec, v, exp_v;
    logic served;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;

    channel_interrupt_control i_channel_interrupt_control (.mclk(mclk), .nrst(nrst),
        .clk_en(clk_en), .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .pending_events(pending), .chain_enable_input(chain_in),
        .interrupt_acknowledge_strobe(strobe), .base_vector(base),
        .channel_irq_request(irq_req), .chain_enable_output(chain_out), .vector_data(vec),
        .vector_oe_n(oe_n), .irq(irq));
    ack_partner i_ack_partner (.mclk(mclk), .vector_data(vec), .vector_oe_n(oe_n),
        .interrupt_acknowledge_strobe(strobe), .chain_enable_input(chain_in));

    // ****************************************************************
    // Clock, timeout and verdict
    // ****************************************************************
    initial begin
        forever #10 mclk = ~mclk;
    end
    // Generous ceiling over roughly 700 expected cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t vector %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // ****************************************************************
    // Bus master: hold until waitrequest is seen low at an edge
    // ****************************************************************
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= 4'h3;
        req.write <= wr;
        req.read <= !wr;
        do begin
            @(posedge mclk);
        end while (waitreq !== 1'b0);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_word(q, exp);
    endtask
    // Which types carry status for a select code
    function automatic logic merges(input logic [3:0] s, input int t);
        case (s)
            4'h8, 4'h9: return 1'b1;
            4'ha: return t != 1;
            4'hb: return t >= 3;
            4'hc: return t >= 4;
            4'hd: return t >= 5;
            4'he: return t == 6;
            default: return 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd_chk(OFF_CONTROL, 32'h0);
        wr(OFF_CONTROL, 32'hffff);
        rd_chk(OFF_CONTROL, 32'hfe3f);
        wr(OFF_CONTROL, 32'h0095);
        rd_chk(OFF_CONTROL, 32'h002a);
        wr(OFF_CONTROL, 32'h007f);
        rd_chk(OFF_CONTROL, 32'h002a);
        wr(OFF_CONTROL, 32'h0015);
        rd_chk(OFF_CONTROL, 32'h002a);
        rd_chk(4'h6, 32'h0);
        // Walk one enable at a time, matched against its own request line
        for (int i = 0; i < 6; i++) begin
            wr(OFF_CONTROL, 32'h80bf);
            wr(OFF_CONTROL, 32'h80c0 | (32'h1 << i));
            rd_chk(OFF_CONTROL, 32'h8000 | (32'h1 << i));
            pending <= 6'h3f ^ (6'h01 << i);
            @(posedge mclk);
            chk_flag(irq_req, 1'b0);
            pending <= 6'h01 << i;
            @(posedge mclk);
            chk_flag(irq_req, 1'b1);
        end
        wr(OFF_CONTROL, 32'h0000);
        chk_flag(irq_req, 1'b0);
        chk_flag(chain_out, 1'b1);
        wr(OFF_CONTROL, 32'h4000);
        chk_flag(chain_out, 1'b0);
        // Every select code against every type, prompt and slow acknowledges
        wr(OFF_CONTROL, 32'h00ff);
        for (int s = 0; s < 16; s++) begin
            wr(OFF_CONTROL, {16'h0, 3'b100, s[3:0], 9'h000});
            for (int t = 1; t <= 6; t++) begin
                pending <= 6'h01 << (t - 1);
                i_ack_partner.ack(2 + t % 3, 1'b1, v, served);
                exp_v = merges(s[3:0], t) ? {base[7:4], t[2:0], base[0]} : base;
                chk_flag(served, 1'b1);
                chk_vec(v, exp_v);
            end
        end
        i_ack_partner.ack(3, 1'b0, v, served);
        chk_flag(served, 1'b0);
        rd_chk(OFF_EVENT, 32'h5);
        wr(OFF_MASK, 32'h1);
        chk_flag(irq, 1'b1);
        wr(OFF_EVENT, 32'h1);
        chk_flag(irq, 1'b0);
        // No-vector mode: acknowledge served silently
        wr(OFF_CONTROL, 32'ha000);
        i_ack_partner.ack(4, 1'b1, v, served);
        chk_flag(served, 1'b0);
        rd_chk(OFF_EVENT, 32'h6);
        wr(OFF_MASK, 32'h2);
        chk_flag(irq, 1'b1);
        wr(OFF_EVENT, 32'h2);
        chk_flag(irq, 1'b0);
        // Frozen clock enable stalls a read until it returns
        clk_en <= 1'b0;
        fork
            begin
                repeat (4) @(posedge mclk);
                clk_en <= 1'b1;
            end
        join_none
        rd_chk(OFF_CONTROL, 32'ha03f);
        close_out();
    end
endmodule
`default_nettype wire
